// ### rtl/mac_pkg.sv
// package: constants, types and helpers of the multiply-accumulate unit
package mac_pkg;
   localparam int OP_W   = 36;
   localparam int ACC_W  = 72;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int LANE9  = 9;
   localparam int LANE18 = 18;
   // register byte offsets
   localparam logic [ADDR_W-1:0] OFS_CTRL    = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_SEL     = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_MASK    = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_ACC_LO  = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_ACC_MID = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_ACC_HI  = 8'h18;
   // control register fields
   localparam int CTRL_W         = 5;
   localparam int CTRL_IN_EN     = 0;
   localparam int CTRL_PIPE_EN   = 1;
   localparam int CTRL_SIGNED    = 2;
   localparam int CTRL_WIDTH_LSB = 3;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h10;
   // source select fields, two bits each
   localparam int SEL_W     = 16;
   localparam int SEL_CE_A  = 0;
   localparam int SEL_CE_B  = 2;
   localparam int SEL_CE_P  = 4;
   localparam int SEL_CE_O  = 6;
   localparam int SEL_RST_A = 8;
   localparam int SEL_RST_B = 10;
   localparam int SEL_RST_P = 12;
   localparam int SEL_RST_O = 14;
   localparam logic [SEL_W-1:0] SEL_RESET = 16'h0000;
   // status and mask fields
   localparam int STAT_W    = 2;
   localparam int STAT_OVF  = 0;
   localparam int STAT_LOAD = 1;
   localparam logic [STAT_W-1:0] STAT_RESET = 2'h0;

   typedef enum logic [1:0] {
      MAC_W9  = 2'b00,
      MAC_W18 = 2'b01,
      MAC_W36 = 2'b10
   } mac_width_t;

   // one of four shared enable or reset sources
   function automatic logic mac_pick(input logic [3:0] src, input logic [1:0] sel);
      return src[sel];
   endfunction
endpackage

// ### rtl/mac_mult.sv
// multiplier array: one 36x36, two 18x18 or four 9x9 lanes, products summed
`timescale 1ns/1ps
`default_nettype none
module mac_mult
   import mac_pkg::*;
(
   input  wire logic [OP_W-1:0]  a_in,
   input  wire logic [OP_W-1:0]  b_in,
   input  wire logic [1:0]       width_in,
   input  wire logic             signed_in,
   output logic      [ACC_W-1:0] prod_out
);
   // extend a lane of w bits to the accumulator width, zero or sign fill
   function automatic logic [ACC_W-1:0] lane_ext(input logic [OP_W-1:0] v, input int w,
                                                input logic sgn);
      logic [ACC_W-1:0] t;
      t = {v, {OP_W{1'b0}}} << (OP_W - w);
      if (sgn)
         return $unsigned($signed(t) >>> (ACC_W - w));
      return t >> (ACC_W - w);
   endfunction

   // products modulo the accumulator width stay exact for two's complement
   function automatic logic [ACC_W-1:0] lane_mul(input logic [OP_W-1:0] a, input logic [OP_W-1:0] b,
                                                input int w, input logic sgn);
      return lane_ext(a, w, sgn) * lane_ext(b, w, sgn);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      prod_out = '0;
      case (mac_width_t'(width_in))
         MAC_W9:
         begin
            for (int i = 0; i < 4; i++)
               prod_out = prod_out + lane_mul(a_in >> (i * LANE9), b_in >> (i * LANE9),
                                              LANE9, signed_in);
         end
         MAC_W18:
         begin
            for (int i = 0; i < 2; i++)
               prod_out = prod_out + lane_mul(a_in >> (i * LANE18), b_in >> (i * LANE18),
                                              LANE18, signed_in);
         end
         default:
            prod_out = lane_mul(a_in, b_in, OP_W, signed_in);
      endcase
   end
endmodule // mac_mult
`default_nettype wire

// ### rtl/mac_stage.sv
// optional register stage with selectable enable and reset sources
`timescale 1ns/1ps
`default_nettype none
module mac_stage
   import mac_pkg::*;
#(
   parameter int W = OP_W
)
(
   input  wire logic         clk_in,
   input  wire logic         rst_n_in,
   input  wire logic [3:0]   ce_src_in,
   input  wire logic [3:0]   rst_src_in,
   input  wire logic [1:0]   ce_sel_in,
   input  wire logic [1:0]   rst_sel_in,
   input  wire logic         use_in,
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);
   typedef struct packed {
      logic [W-1:0] data;
   } mac_stage_t;

   mac_stage_t st;
   mac_stage_t next_st;
   logic       ce;
   logic       rst;

   assign ce  = mac_pick(ce_src_in, ce_sel_in);
   assign rst = mac_pick(rst_src_in, rst_sel_in);

   always_comb
   begin
      next_st = st;
      if (rst)
         next_st.data = '0;
      else if (ce)
         next_st.data = d_in;
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         st <= '0;
      else
         st <= next_st;
   end

   assign q_out = use_in ? st.data : d_in;

   ////////////////////////////////////////////////////////////////////////////////
   property p_stage_bypass;
      @(posedge clk_in) disable iff (!rst_n_in)
      !use_in |-> q_out == d_in;
   endproperty
   a_stage_bypass: assert property (p_stage_bypass)
      else $error("bypassed stage does not pass its input");

   property p_stage_sources;
      @(posedge clk_in) disable iff (!rst_n_in)
      (rst || ce) |=> st.data == ($past(rst) ? '0 : $past(d_in));
   endproperty
   a_stage_sources: assert property (p_stage_sources)
      else $error("stage ignores its selected enable or reset");
endmodule // mac_stage
`default_nettype wire

// ### rtl/mac_unit.sv
// multiply-accumulate unit: operand stages, multiplier, accumulator, registers
//
// How it works
// - multiply A by B, add to held total, present new total at output.
// - input and pipeline stages selectable as used or bypassed; output stage always.
// - accumulator can be loaded with a starting value while running.
// - overflow output comes from a register aligned with the accumulator.
// - unsigned mode wraps and flags overflow when the sum is below prior total.
// - signed mode flags when like-signed addends give an opposite-signed sum.
// - overflow is a one-cycle pulse; accumulation continues from wrapped value.
// - each register picks one of four enables and one of four resets.
// - native 9, 18 and 36 bit signed and unsigned operands.
// - block works as one 36x36, two 18x18 or four 9x9 lanes.
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module mac_unit
   import mac_pkg::*;
(
   input  wire logic              SYS_CLK_IN,
   input  wire logic              RST_N_IN,
   input  wire logic [OP_W-1:0]   A_IN,
   input  wire logic [OP_W-1:0]   B_IN,
   input  wire logic              CLOCK_ENABLE_SOURCE_ZERO_IN,
   input  wire logic              CLOCK_ENABLE_SOURCE_ONE_IN,
   input  wire logic              CLOCK_ENABLE_SOURCE_TWO_IN,
   input  wire logic              CLOCK_ENABLE_SOURCE_THREE_IN,
   input  wire logic              RESET_SOURCE_ZERO_IN,
   input  wire logic              RESET_SOURCE_ONE_IN,
   input  wire logic              RESET_SOURCE_TWO_IN,
   input  wire logic              RESET_SOURCE_THREE_IN,
   input  wire logic              LOAD_IN,
   input  wire logic [ACC_W-1:0]  LOAD_VALUE_IN,
   input  wire logic [ADDR_W-1:0] ADDR_IN,
   input  wire logic [DATA_W-1:0] WR_DATA_IN,
   input  wire logic              WR_IN,
   input  wire logic              RD_IN,
   output logic      [DATA_W-1:0] RD_DATA_OUT,
   output logic      [ACC_W-1:0]  ACC_OUT,
   output logic                   OVERFLOW_OUT,
   output logic                   IRQ_OUT
);
   typedef struct packed {
      logic [CTRL_W-1:0] ctrl;
      logic [SEL_W-1:0]  sel;
      logic [STAT_W-1:0] status;
      logic [STAT_W-1:0] mask;
      logic [ACC_W-1:0]  acc;
      logic              ovf;
      logic [DATA_W-1:0] rd_data;
   } mac_unit_t;

   mac_unit_t          st;
   mac_unit_t          next_st;
   logic [3:0]         ce_src;
   logic [3:0]         rst_src;
   logic [OP_W-1:0]    a_q;
   logic [OP_W-1:0]    b_q;
   logic [ACC_W-1:0]   prod;
   logic [ACC_W-1:0]   prod_q;
   logic [ACC_W-1:0]   sum;
   logic               ce_out;
   logic               rst_out;
   logic               is_signed;
   logic               wrap_u;
   logic               wrap_s;
   logic               wrap;
   logic               acc_upd;
   logic               load_take;
   logic [STAT_W-1:0]  events;
   logic [STAT_W-1:0]  clr;

   assign ce_src  = {CLOCK_ENABLE_SOURCE_THREE_IN, CLOCK_ENABLE_SOURCE_TWO_IN,
                     CLOCK_ENABLE_SOURCE_ONE_IN, CLOCK_ENABLE_SOURCE_ZERO_IN};
   assign rst_src = {RESET_SOURCE_THREE_IN, RESET_SOURCE_TWO_IN,
                     RESET_SOURCE_ONE_IN, RESET_SOURCE_ZERO_IN};
   assign is_signed = st.ctrl[CTRL_SIGNED];

   ////////////////////////////////////////////////////////////////////////////////
   // operand input stages
   mac_stage #(
      .W          (OP_W)
   ) u_in_a (
      .clk_in     (SYS_CLK_IN),
      .rst_n_in   (RST_N_IN),
      .ce_src_in  (ce_src),
      .rst_src_in (rst_src),
      .ce_sel_in  (st.sel[SEL_CE_A +: 2]),
      .rst_sel_in (st.sel[SEL_RST_A +: 2]),
      .use_in     (st.ctrl[CTRL_IN_EN]),
      .d_in       (A_IN),
      .q_out      (a_q)
   );

   mac_stage #(
      .W          (OP_W)
   ) u_in_b (
      .clk_in     (SYS_CLK_IN),
      .rst_n_in   (RST_N_IN),
      .ce_src_in  (ce_src),
      .rst_src_in (rst_src),
      .ce_sel_in  (st.sel[SEL_CE_B +: 2]),
      .rst_sel_in (st.sel[SEL_RST_B +: 2]),
      .use_in     (st.ctrl[CTRL_IN_EN]),
      .d_in       (B_IN),
      .q_out      (b_q)
   );

   mac_mult u_mult (
      .a_in       (a_q),
      .b_in       (b_q),
      .width_in   (st.ctrl[CTRL_WIDTH_LSB +: 2]),
      .signed_in  (is_signed),
      .prod_out   (prod)
   );

   // the pipeline stage splits the multiplier from the adder for timing
   mac_stage #(
      .W          (ACC_W)
   ) u_pipe (
      .clk_in     (SYS_CLK_IN),
      .rst_n_in   (RST_N_IN),
      .ce_src_in  (ce_src),
      .rst_src_in (rst_src),
      .ce_sel_in  (st.sel[SEL_CE_P +: 2]),
      .rst_sel_in (st.sel[SEL_RST_P +: 2]),
      .use_in     (st.ctrl[CTRL_PIPE_EN]),
      .d_in       (prod),
      .q_out      (prod_q)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // accumulator adder and overflow detection
   // output stage sources
   assign ce_out  = mac_pick(ce_src, st.sel[SEL_CE_O +: 2]);
   assign rst_out = mac_pick(rst_src, st.sel[SEL_RST_O +: 2]);

   assign sum = st.acc + prod_q;

   assign wrap_u = sum < st.acc;
   assign wrap_s = (st.acc[ACC_W-1] == prod_q[ACC_W-1]) && (sum[ACC_W-1] != st.acc[ACC_W-1]);
   assign wrap = is_signed ? wrap_s : wrap_u;

   // a load wins over the add; both need the output enable
   assign load_take = !rst_out && ce_out && LOAD_IN;
   assign acc_upd   = !rst_out && ce_out && !LOAD_IN;
   assign events    = {load_take, acc_upd && wrap};

   // a one written to a status bit clears it
   assign clr = (WR_IN && ADDR_IN == OFS_STATUS) ? WR_DATA_IN[STAT_W-1:0] : '0;

   ////////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      next_st = st;
      next_st.rd_data = '0;
      next_st.ovf = 1'b0;
      if (rst_out)
      begin
         next_st.acc = '0;
      end
      else if (load_take)
      begin
         next_st.acc = LOAD_VALUE_IN;
      end
      else if (acc_upd)
      begin
         next_st.acc = sum;
         next_st.ovf = wrap;
      end
      // set wins over a same-cycle clear
      next_st.status = (st.status & ~clr) | events;
      if (WR_IN)
      begin
         case (ADDR_IN)
            OFS_CTRL:
               next_st.ctrl = WR_DATA_IN[CTRL_W-1:0];
            OFS_SEL:
               next_st.sel = WR_DATA_IN[SEL_W-1:0];
            OFS_MASK:
               next_st.mask = WR_DATA_IN[STAT_W-1:0];
            default:
               next_st.mask = st.mask;
         endcase
      end
      if (RD_IN)
      begin
         case (ADDR_IN)
            OFS_CTRL:
               next_st.rd_data = DATA_W'(st.ctrl);
            OFS_SEL:
               next_st.rd_data = DATA_W'(st.sel);
            OFS_STATUS:
               next_st.rd_data = DATA_W'(st.status);
            OFS_MASK:
               next_st.rd_data = DATA_W'(st.mask);
            OFS_ACC_LO:
               next_st.rd_data = st.acc[31:0];
            OFS_ACC_MID:
               next_st.rd_data = st.acc[63:32];
            OFS_ACC_HI:
               next_st.rd_data = DATA_W'(st.acc[ACC_W-1:64]);
            default:
               next_st.rd_data = '0;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
      begin
         st        <= '0;
         st.ctrl   <= CTRL_RESET;
         st.sel    <= SEL_RESET;
         st.status <= STAT_RESET;
      end
      else
         st <= next_st;
   end

   assign RD_DATA_OUT  = st.rd_data;
   assign ACC_OUT      = st.acc;
   assign OVERFLOW_OUT = st.ovf;
   assign IRQ_OUT      = |(st.status & st.mask);

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   property p_acc_add;
      @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      acc_upd |=> ACC_OUT == $past(st.acc) + $past(prod_q);
   endproperty
   a_acc_add: assert property (p_acc_add)
      else $error("accumulator did not add the product");

   property p_out_hold;
      @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      !ce_out && !rst_out |=> $stable(ACC_OUT) && !OVERFLOW_OUT;
   endproperty
   a_out_hold: assert property (p_out_hold)
      else $error("output register moved without its enable");

   property p_load;
      @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      load_take |=> ACC_OUT == $past(LOAD_VALUE_IN) && !OVERFLOW_OUT && st.status[STAT_LOAD];
   endproperty
   a_load: assert property (p_load)
      else $error("dynamic load not taken");

   property p_ovf_cause;
      @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      OVERFLOW_OUT |-> $past(acc_upd) && $past(wrap) && st.status[STAT_OVF];
   endproperty
   a_ovf_cause: assert property (p_ovf_cause)
      else $error("overflow raised without a wrapping add");

   property p_unsigned_wrap;
      @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      acc_upd && !is_signed && (st.acc + prod_q) < st.acc |=> OVERFLOW_OUT;
   endproperty
   a_unsigned_wrap: assert property (p_unsigned_wrap)
      else $error("unsigned wrap not flagged");

   property p_unsigned_quiet;
      @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      acc_upd && !is_signed && (st.acc + prod_q) >= st.acc |=> !OVERFLOW_OUT;
   endproperty
   a_unsigned_quiet: assert property (p_unsigned_quiet)
      else $error("unsigned add flagged without a wrap");

   property p_signed_wrap;
      @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      acc_upd && is_signed && !st.acc[ACC_W-1] && !prod_q[ACC_W-1] && sum[ACC_W-1]
         |=> OVERFLOW_OUT;
   endproperty
   a_signed_wrap: assert property (p_signed_wrap)
      else $error("signed positive wrap not flagged");

   property p_signed_neg;
      @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      acc_upd && is_signed && st.acc[ACC_W-1] && prod_q[ACC_W-1] && !sum[ACC_W-1]
         |=> OVERFLOW_OUT;
   endproperty
   a_signed_neg: assert property (p_signed_neg)
      else $error("signed negative wrap not flagged");

   property p_pulse;
      @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      OVERFLOW_OUT && !acc_upd |=> !OVERFLOW_OUT;
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("overflow held beyond one cycle");

   property p_out_reset;
      @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      rst_out |=> ACC_OUT == '0 && !OVERFLOW_OUT;
   endproperty
   a_out_reset: assert property (p_out_reset)
      else $error("selected reset did not clear the output stage");

   property p_mode;
      @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      acc_upd && (wrap_u != wrap_s) |=> OVERFLOW_OUT == ($past(is_signed) ? $past(wrap_s)
                                                                           : $past(wrap_u));
   endproperty
   a_mode: assert property (p_mode)
      else $error("overflow test does not follow the sign mode");

   property p_irq;
      @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      OVERFLOW_OUT && st.mask[STAT_OVF] |-> IRQ_OUT;
   endproperty
   a_irq: assert property (p_irq)
      else $error("unmasked overflow did not raise the interrupt");

   // independent product references; lanes widened before multiplying
   property p_prod_x36;
      @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      st.ctrl[CTRL_WIDTH_LSB +: 2] == 2'h2 && !is_signed
         |-> prod == {36'h0, a_q} * {36'h0, b_q};
   endproperty
   a_prod_x36: assert property (p_prod_x36)
      else $error("wide unsigned product wrong");

   property p_prod_x18;
      @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      st.ctrl[CTRL_WIDTH_LSB +: 2] == 2'h1 && !is_signed
         |-> prod == {54'h0, a_q[17:0]} * {54'h0, b_q[17:0]}
                   + {54'h0, a_q[35:18]} * {54'h0, b_q[35:18]};
   endproperty
   a_prod_x18: assert property (p_prod_x18)
      else $error("two-lane product sum wrong");

   property p_acc_read;
      @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      RD_IN && ADDR_IN == OFS_ACC_HI |=> RD_DATA_OUT == DATA_W'($past(ACC_OUT[ACC_W-1:64]));
   endproperty
   a_acc_read: assert property (p_acc_read)
      else $error("upper accumulator word not presented");
endmodule // mac_unit
`default_nettype wire

// ### verification/mac_fabric_model.sv
// fabric-side partner: extends narrow operands per lane and counts overflow pulses
`timescale 1ns/1ps
`default_nettype none
module mac_fabric_model
   import mac_pkg::*;
(
   input  wire logic            clk_in,
   input  wire logic            rst_n_in,
   input  wire logic [3:0]      a_in,
   input  wire logic [3:0]      b_in,
   input  wire logic [1:0]      width_in,
   input  wire logic            signed_in,
   input  wire logic            ovf_in,
   output logic      [OP_W-1:0] a_out,
   output logic      [OP_W-1:0] b_out,
   output logic      [7:0]      ovf_cnt_out
);
   int lw;
   int off;
   ////////////////////////////////////////////////////////////////////////////////
   // fill or extend
   // the same narrow value goes to every lane, so the sum scales with the lane count
   always_comb
   begin
      lw = (width_in == MAC_W9) ? LANE9 : ((width_in == MAC_W18) ? LANE18 : OP_W);
      for (int i = 0; i < OP_W; i++)
      begin
         off = i % lw;
         a_out[i] = (off < 4) ? a_in[off[1:0]] : (signed_in & a_in[3]);
         b_out[i] = (off < 4) ? b_in[off[1:0]] : (signed_in & b_in[3]);
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // count overflow pulses
   // eight bits only: a wider total would need a wider counter
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         ovf_cnt_out <= 8'h00;
      else if (ovf_in)
         ovf_cnt_out <= ovf_cnt_out + 8'h01;
   end
endmodule // mac_fabric_model
`default_nettype wire

// ### verification/mac_unit_bench.sv
// self-checking bench of the multiply-accumulate unit
`timescale 1ns/1ps
`default_nettype none
module mac_unit_bench
   import mac_pkg::*;
;
   logic              clk;
   logic              rst_n;
   logic [3:0]        pa;
   logic [3:0]        pb;
   logic [3:0]        ce;
   logic [3:0]        rs;
   logic              ld;
   logic [ACC_W-1:0]  ld_val;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic              wr;
   logic              rd;
   logic [1:0]        wid;
   logic              sgn;
   logic [DATA_W-1:0] rdata;
   logic [ACC_W-1:0]  acc;
   logic              ovf;
   logic              irq;
   logic [OP_W-1:0]   a_bus;
   logic [OP_W-1:0]   b_bus;
   logic [7:0]        ovf_cnt;
   int                error_cnt;
   int                total_checks;
   int                cyc;

   mac_unit mac_unit_inst (
      .SYS_CLK_IN                   (clk),
      .RST_N_IN                     (rst_n),
      .A_IN                         (a_bus),
      .B_IN                         (b_bus),
      .CLOCK_ENABLE_SOURCE_ZERO_IN  (ce[0]),
      .CLOCK_ENABLE_SOURCE_ONE_IN   (ce[1]),
      .CLOCK_ENABLE_SOURCE_TWO_IN   (ce[2]),
      .CLOCK_ENABLE_SOURCE_THREE_IN (ce[3]),
      .RESET_SOURCE_ZERO_IN         (rs[0]),
      .RESET_SOURCE_ONE_IN          (rs[1]),
      .RESET_SOURCE_TWO_IN          (rs[2]),
      .RESET_SOURCE_THREE_IN        (rs[3]),
      .LOAD_IN                      (ld),
      .LOAD_VALUE_IN                (ld_val),
      .ADDR_IN                      (addr),
      .WR_DATA_IN                   (wdata),
      .WR_IN                        (wr),
      .RD_IN                        (rd),
      .RD_DATA_OUT                  (rdata),
      .ACC_OUT                      (acc),
      .OVERFLOW_OUT                 (ovf),
      .IRQ_OUT                      (irq)
   );
   mac_fabric_model mac_fabric_model_inst (
      .clk_in      (clk),
      .rst_n_in    (rst_n),
      .a_in        (pa),
      .b_in        (pb),
      .width_in    (wid),
      .signed_in   (sgn),
      .ovf_in      (ovf),
      .a_out       (a_bus),
      .b_out       (b_bus),
      .ovf_cnt_out (ovf_cnt)
   );
   ////////////////////////////////////////////////////////////////////////////////
   always #5 clk = ~clk;

   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // hang guard: the whole sequence needs under a hundred cycles
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         error_cnt++;
         close_out();
      end
   end

   task automatic chk(input logic [ACC_W-1:0] seen, input logic [ACC_W-1:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask

   task automatic set_ctrl(input logic [CTRL_W-1:0] v);
      wr_reg(OFS_CTRL, DATA_W'(v));
      wid <= v[4:3];
      sgn <= v[2];
   endtask

   // one enabled cycle only, so each call adds at most one product
   task automatic op(input logic [3:0] a, input logic [3:0] b, input logic [3:0] m);
      @(posedge clk);
      pa <= a;
      pb <= b;
      ce <= m;
      @(posedge clk);
      pa <= 4'h0;
      pb <= 4'h0;
      ce <= 4'h0;
      #1;
   endtask

   task automatic load(input logic [ACC_W-1:0] v);
      @(posedge clk);
      ld <= 1'b1;
      ld_val <= v;
      ce <= 4'h1;
      @(posedge clk);
      ld <= 1'b0;
      ce <= 4'h0;
      #1;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      clk = 1'b0;
      rst_n = 1'b1;
      pa = 4'h0;
      pb = 4'h0;
      ce = 4'h0;
      rs = 4'h0;
      ld = 1'b0;
      ld_val = 72'h0;
      addr = 8'h00;
      wdata = 32'h0;
      wr = 1'b0;
      rd = 1'b0;
      wid = 2'h2;
      sgn = 1'b0;
      error_cnt = 0;
      total_checks = 0;
      cyc = 0;
      // a real falling edge, so every asynchronous reset is sure to fire
      #1 rst_n = 1'b0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      rd_reg(OFS_CTRL, 32'h10);
      rd_reg(OFS_SEL, 32'h0);
      rd_reg(8'h40, 32'h0);
      op(4'h3, 4'h4, 4'h1);
      chk(acc, 72'hC);
      set_ctrl(5'h08);
      op(4'h3, 4'h4, 4'h1);
      chk(acc, 72'h24);
      set_ctrl(5'h00);
      op(4'h3, 4'h4, 4'h1);
      chk(acc, 72'h54);
      set_ctrl(5'h04);
      op(4'hA, 4'h5, 4'h1);
      chk(acc, 72'h54 - 72'h78);
      chk(ovf, 1'b0);
      wr_reg(OFS_MASK, 32'h1);
      set_ctrl(5'h10);
      load(72'hFF_FFFF_FFFF_FFFF_FFF0);
      chk(acc, 72'hFF_FFFF_FFFF_FFFF_FFF0);
      chk(irq, 1'b0);
      rd_reg(OFS_ACC_HI, 32'hFF);
      op(4'h5, 4'h4, 4'h1);
      chk(acc, 72'h4);
      chk(ovf, 1'b1);
      chk(irq, 1'b1);
      @(posedge clk);
      #1 chk(ovf, 1'b0);
      rd_reg(OFS_STATUS, 32'h3);
      wr_reg(OFS_STATUS, 32'h1);
      rd_reg(OFS_STATUS, 32'h2);
      chk(irq, 1'b0);
      set_ctrl(5'h14);
      load(72'h7F_FFFF_FFFF_FFFF_FFFF);
      op(4'h1, 4'h1, 4'h1);
      chk(ovf, 1'b1);
      chk(acc, 72'h80_0000_0000_0000_0000);
      load(72'h80_0000_0000_0000_0000);
      op(4'hF, 4'h1, 4'h1);
      chk(ovf, 1'b1);
      chk(acc, 72'h7F_FFFF_FFFF_FFFF_FFFF);
      set_ctrl(5'h10);
      load(72'h7F_FFFF_FFFF_FFFF_FFFF);
      op(4'h1, 4'h1, 4'h1);
      chk(ovf, 1'b0);
      // both stages used: flush stale stage contents under a held load first
      set_ctrl(5'h13);
      @(posedge clk);
      ce <= 4'h1;
      ld <= 1'b1;
      ld_val <= 72'h0;
      repeat (3) @(posedge clk);
      ld <= 1'b0;
      pa <= 4'h2;
      pb <= 4'h3;
      @(posedge clk);
      pa <= 4'h0;
      pb <= 4'h0;
      @(posedge clk);
      #1 chk(acc, 72'h0);
      @(posedge clk);
      #1 chk(acc, 72'h6);
      @(posedge clk);
      ce <= 4'h0;
      #1 chk(acc, 72'h6);
      set_ctrl(5'h10);
      wr_reg(OFS_SEL, 32'h0080);
      op(4'h3, 4'h4, 4'h1);
      chk(acc, 72'h6);
      op(4'h3, 4'h4, 4'h4);
      chk(acc, 72'h12);
      wr_reg(OFS_SEL, 32'hC080);
      @(posedge clk);
      rs <= 4'h8;
      op(4'h3, 4'h4, 4'h4);
      rs <= 4'h0;
      chk(acc, 72'h0);
      chk(ovf_cnt, 8'h3);
      close_out();
   end
endmodule // mac_unit_bench
`default_nettype wire
